/* core/tick_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// Divides the system clock down to a one-cycle tick enable
module tick_divider
    import toy_timer_pkg::*;
#(
    parameter int DIV = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    // Counts DIV-1 down to zero, so one tick every DIV cycles
    logic [31:0] count;

    // ----------------------------------------------------------------
    // Divider counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'h0) begin
            // Reload and emit the tick
            count <= 32'(DIV - 1);
            tick <= 1'b1;
        end else begin
            count <= count - 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* core/toy_interval_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module toy_interval_timer
    import toy_timer_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES  // Cycles per 10 ms tick
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic IPR_WR,             // Register write strobe
    input wire logic IPR_RD,             // Register read strobe
    input wire logic [7:0] IPR_NUM,      // Register number
    input wire logic [31:0] IPR_WDATA,   // Write data
    output logic [31:0] IPR_RDATA,       // Read data, registered
    output logic IPR_RD_VALID,           // Read data valid pulse
    input wire logic BATTERY_LOW_FLAG,   // Battery-low level from config logic
    input wire logic INIT_DONE,          // Initialization complete
    input wire logic DC_POWER_GOOD,      // Power good level
    input wire logic CPU_HALTED,         // Processor halted level
    output logic IRQ_REQ,                // Pending interval request
    output logic [4:0] IRQ_LEVEL,        // Request level
    output logic [7:0] IRQ_VECTOR,       // Vector supplied on claim
    input wire logic IACK,               // Acknowledge strobe
    input wire logic [4:0] IACK_LEVEL,   // Level being acknowledged
    output logic IRQ_CLAIM               // This block owns the acknowledge
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [31:0] time_of_year_counter;  // Time-of-year count
    logic interval_irq_enable;          // Sole programmable interval state
    logic pending;                      // Interval request latch
    logic tick;                         // 10 ms enable pulse
    logic [1:0] battery_sync, init_sync, pwr_sync, halt_sync; // Pin synchronisers
    logic battery_armed;                // Last sampled flag-after-init level
    logic pwr_last;                     // Last sampled power-good level
    logic battery_rise;                 // Battery-low newly seen after init
    logic pwr_fall;                     // Power-good lost while halted
    logic wr_toy, wr_ctl, rd_toy, rd_ctl;
    logic ack_ours;                     // Acknowledge at our level

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    tick_divider #(.DIV(TICK_DIV)) u_tick (
        .clk(CLK),
        .rst(RST),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // These levels come from outside logic and may change at any time
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            battery_sync <= 2'h0;
            init_sync <= 2'h0;
            pwr_sync <= 2'h0;
            halt_sync <= 2'h0;
        end else begin
            battery_sync <= {battery_sync[0], BATTERY_LOW_FLAG};
            init_sync <= {init_sync[0], INIT_DONE};
            pwr_sync <= {pwr_sync[0], DC_POWER_GOOD};
            halt_sync <= {halt_sync[0], CPU_HALTED};
        end
    end

    // Edge history, read only from the second stage
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            battery_armed <= 1'b0;
            pwr_last <= 1'b0;
        end else begin
            battery_armed <= battery_sync[1] & init_sync[1];
            pwr_last <= pwr_sync[1];
        end
    end

    // Edge only: a held flag must not block a later software reload
    assign battery_rise = battery_sync[1] & init_sync[1] & ~battery_armed;
    assign pwr_fall = pwr_last & ~pwr_sync[1] & halt_sync[1];

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    assign wr_toy = IPR_WR && (IPR_NUM == TIME_OF_YEAR_COUNT_IDX);
    assign wr_ctl = IPR_WR && (IPR_NUM == INTERVAL_CLOCK_CONTROL_IDX);
    assign rd_toy = IPR_RD && (IPR_NUM == TIME_OF_YEAR_COUNT_IDX);
    assign rd_ctl = IPR_RD && (IPR_NUM == INTERVAL_CLOCK_CONTROL_IDX);

    // ----------------------------------------------------------------
    // Time-of-year counter
    // ----------------------------------------------------------------
    // Software write beats both the tick and a battery-low clear, so a
    // reload issued right as the flag appears is never thrown away
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            time_of_year_counter <= TIME_OF_YEAR_RST;
        end else if (wr_toy) begin
            time_of_year_counter <= IPR_WDATA;
        end else if (battery_rise) begin
            time_of_year_counter <= 32'h0;
        end else if (tick && time_of_year_counter != 32'h0) begin
            time_of_year_counter <= time_of_year_counter + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Interval control
    // ----------------------------------------------------------------
    // Only bit 6 is stored; no reload or count register exists
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            interval_irq_enable <= INTERVAL_IRQ_ENABLE_RST;
        end else if (pwr_fall) begin
            interval_irq_enable <= 1'b0;
        end else if (wr_ctl) begin
            interval_irq_enable <= IPR_WDATA[INTERVAL_IRQ_ENABLE_POS];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    // Level sixteen acknowledges go to this block first while it pends
    assign ack_ours = IACK && (IACK_LEVEL == INTERVAL_LEVEL) && pending;
    assign IRQ_CLAIM = ack_ours;
    assign IRQ_REQ = pending;

    // A tick in the acknowledge cycle re-arms the request: set wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pending <= 1'b0;
        end else if (!interval_irq_enable || pwr_fall || (wr_ctl &&
                     !IPR_WDATA[INTERVAL_IRQ_ENABLE_POS])) begin
            pending <= 1'b0;
        end else if (tick) begin
            pending <= 1'b1;
        end else if (ack_ours) begin
            pending <= 1'b0;
        end
    end

    // Identity held in flops so it stays clean on the output pins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IRQ_LEVEL <= INTERVAL_LEVEL;
            IRQ_VECTOR <= INTERVAL_VECTOR;
        end else begin
            IRQ_LEVEL <= INTERVAL_LEVEL;
            IRQ_VECTOR <= INTERVAL_VECTOR;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unknown register numbers read as zero rather than stalling
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IPR_RDATA <= 32'h0;
            IPR_RD_VALID <= 1'b0;
        end else begin
            IPR_RD_VALID <= IPR_RD;
            if (rd_toy) begin
                IPR_RDATA <= time_of_year_counter;
            end else if (rd_ctl) begin
                IPR_RDATA <= 32'(interval_irq_enable) << INTERVAL_IRQ_ENABLE_POS;
            end else begin
                IPR_RDATA <= 32'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_tick_run;
        tick && !wr_toy && !battery_rise && time_of_year_counter != 32'h0;
    endsequence

    sequence s_ack_quiet;
        ack_ours && !tick;
    endsequence

    toy_incr_a: assert property (@(posedge CLK) disable iff (RST)
        s_tick_run |=> time_of_year_counter == $past(time_of_year_counter) + 32'h1)
        else $error("counter did not advance on tick");
    toy_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (time_of_year_counter == 32'h0 && !wr_toy) |=> time_of_year_counter == 32'h0)
        else $error("zero counter moved without a write");
    battery_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (battery_rise && !wr_toy) |=> time_of_year_counter == 32'h0)
        else $error("battery low did not clear counter");
    toy_write_a: assert property (@(posedge CLK) disable iff (RST)
        wr_toy |=> time_of_year_counter == $past(IPR_WDATA))
        else $error("counter write not loaded");
    irq_tick_a: assert property (@(posedge CLK) disable iff (RST)
        (tick && interval_irq_enable && !pwr_fall && !wr_ctl) |=> IRQ_REQ)
        else $error("enabled tick raised no request");
    irq_off_a: assert property (@(posedge CLK) disable iff (RST)
        !interval_irq_enable |=> !IRQ_REQ)
        else $error("request while disabled");
    pwr_clear_a: assert property (@(posedge CLK) disable iff (RST)
        pwr_fall |=> !interval_irq_enable)
        else $error("enable survived power fail while halted");
    ctl_read_a: assert property (@(posedge CLK) disable iff (RST)
        rd_ctl |=> IPR_RD_VALID && IPR_RDATA[31:7] == 25'h0 && IPR_RDATA[5:0] == 6'h0)
        else $error("reserved control bits read nonzero");
    irq_ident_a: assert property (@(posedge CLK) disable iff (RST)
        IRQ_REQ |-> IRQ_LEVEL == 5'h10 && IRQ_VECTOR == 8'hc0)
        else $error("wrong level or vector");
    ack_clear_a: assert property (@(posedge CLK) disable iff (RST)
        s_ack_quiet |=> !IRQ_REQ ##1 (!IRQ_REQ || $past(tick)))
        else $error("request not cleared by acknowledge");
endmodule
`default_nettype wire

/* core/toy_timer_pkg.sv */
`default_nettype none
package toy_timer_pkg;
    // ----------------------------------------------------------------
    // Internal register numbers
    // ----------------------------------------------------------------
    localparam logic [7:0] INTERVAL_CLOCK_CONTROL_IDX = 8'h18; // Interval control
    localparam logic [7:0] TIME_OF_YEAR_COUNT_IDX = 8'h1b;     // Time-of-year count

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int INTERVAL_IRQ_ENABLE_POS = 6;       // Enable bit position
    localparam logic INTERVAL_IRQ_ENABLE_RST = 1'b0;  // Enable off after reset
    localparam logic [31:0] TIME_OF_YEAR_RST = 32'h0000_0000; // Counter after reset

    // ----------------------------------------------------------------
    // Interrupt identity
    // ----------------------------------------------------------------
    localparam logic [4:0] INTERVAL_LEVEL = 5'h10;   // Priority level sixteen
    localparam logic [7:0] INTERVAL_VECTOR = 8'hc0;  // Fixed vector

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;          // 20 MHz system clock
    localparam int TICK_PERIOD_MS = 10;         // 100 Hz time base
    localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

/* sim/time_of_year_and_interval_timer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module time_of_year_and_interval_timer_bench import toy_timer_pkg::*;;
    localparam int DIV = 20; // Short tick so the run stays brief
    logic clk = 1'b0, rst = 1'b1, init_done = 1'b1, pgood = 1'b1, halted = 1'b0;
    logic wr, rd, rd_valid, blow, irq_req, iack, claim, c, ok;
    logic [7:0] num, irq_vec;
    logic [31:0] wdata, rdata, d, d2, v;
    logic [4:0] irq_level, iack_level;
    int errors = 0, compares = 0, n, hits;
    // ----------------------------------------------------------------
    // Clock, instances
    // ----------------------------------------------------------------
    initial begin
        forever #25 clk = ~clk;
    end
    toy_interval_timer #(.TICK_DIV(DIV)) toy_interval_timer_inst (.CLK(clk), .RST(rst),
        .IPR_WR(wr), .IPR_RD(rd), .IPR_NUM(num), .IPR_WDATA(wdata), .IPR_RDATA(rdata),
        .IPR_RD_VALID(rd_valid), .BATTERY_LOW_FLAG(blow), .INIT_DONE(init_done),
        .DC_POWER_GOOD(pgood), .CPU_HALTED(halted), .IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level),
        .IRQ_VECTOR(irq_vec), .IACK(iack), .IACK_LEVEL(iack_level), .IRQ_CLAIM(claim));
    toy_host_model toy_host_model_inst (.CLK(clk), .IPR_WR(wr), .IPR_RD(rd), .IPR_NUM(num),
        .IPR_WDATA(wdata), .IPR_RDATA(rdata), .IPR_RD_VALID(rd_valid), .IACK(iack),
        .IACK_LEVEL(iack_level), .IRQ_CLAIM(claim), .BATTERY_LOW(blow));
    // ----------------------------------------------------------------
    // Comparison, verdict and bounded waits
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Read with a valid check; a missing valid also shows as a mismatch
    task automatic rdchk(input logic [7:0] r, input logic [31:0] exp);
        toy_host_model_inst.rd(r, d, ok);
        check(ok, 1'b1);
        check(d, exp);
    endtask
    // Counts falling edges until a request shows; a hang ends the run
    task automatic wait_req(output int cnt);
        for (cnt = 1; cnt <= 4 * DIV; cnt++) begin
            @(negedge clk);
            if (irq_req === 1'b1) return;
        end
        errors++;
        final_report();
    endtask
    // ----------------------------------------------------------------
    // Main sequence; expected counts come from the loaded value or an earlier read
    // ----------------------------------------------------------------
    initial begin
        v = $urandom(32'h5ee8);
        // Five full rising edges inside reset, released off the sampling edge
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rdchk(TIME_OF_YEAR_COUNT_IDX, 32'h0);
        rdchk(INTERVAL_CLOCK_CONTROL_IDX, 32'h0);
        // Writes to the absent reload and count numbers must leave nothing behind
        toy_host_model_inst.wr(8'h19, v);
        toy_host_model_inst.wr(8'h1a, ~v);
        rdchk(8'h19, 32'h0);
        rdchk(8'h1a, 32'h0);
        repeat (3 * DIV) @(negedge clk);
        rdchk(TIME_OF_YEAR_COUNT_IDX, 32'h0);
        // Random load; a tick may land between write and read
        v = $urandom() | 32'h1;
        toy_host_model_inst.wr(TIME_OF_YEAR_COUNT_IDX, v);
        toy_host_model_inst.rd(TIME_OF_YEAR_COUNT_IDX, d, ok);
        check(ok && (d - v) <= 32'h1, 1'b1);
        // Two samples exactly one tick period apart differ by one
        repeat (DIV - 2) @(negedge clk);
        toy_host_model_inst.rd(TIME_OF_YEAR_COUNT_IDX, d2, ok);
        check(d2, d + 32'h1);
        // Battery low before init leaves the count; init completing clears and pins it
        init_done = 1'b0;
        toy_host_model_inst.low_battery();
        repeat (6) @(negedge clk);
        toy_host_model_inst.rd(TIME_OF_YEAR_COUNT_IDX, d, ok);
        check(ok && d != 32'h0, 1'b1);
        init_done = 1'b1;
        repeat (6) @(negedge clk);
        rdchk(TIME_OF_YEAR_COUNT_IDX, 32'h0);
        repeat (3 * DIV) @(negedge clk);
        rdchk(TIME_OF_YEAR_COUNT_IDX, 32'h0);
        toy_host_model_inst.reload(32'h5);
        toy_host_model_inst.rd(TIME_OF_YEAR_COUNT_IDX, d, ok);
        check(d == 32'h5 || d == 32'h6, 1'b1);
        // Enable, then power fail while halted drops it
        toy_host_model_inst.ctl(1'b1);
        rdchk(INTERVAL_CLOCK_CONTROL_IDX, 32'h40);
        // A power dip while running must leave the enable alone
        pgood = 1'b0;
        repeat (6) @(negedge clk);
        rdchk(INTERVAL_CLOCK_CONTROL_IDX, 32'h40);
        pgood = 1'b1;
        repeat (6) @(negedge clk);
        halted = 1'b1;
        pgood = 1'b0;
        repeat (6) @(negedge clk);
        rdchk(INTERVAL_CLOCK_CONTROL_IDX, 32'h0);
        pgood = 1'b1;
        halted = 1'b0;
        // Requests: claim, pending, spacing, identity
        toy_host_model_inst.ctl(1'b1);
        wait_req(n);
        check(irq_level, 32'h10);
        check(irq_vec, 32'hc0);
        toy_host_model_inst.ack(5'h10, c);
        check(c, 1'b1);
        check(irq_req, 1'b0);
        wait_req(n);
        check(n, DIV - 2);
        toy_host_model_inst.ack(5'h0f, c);
        check(c, 1'b0);
        check(irq_req, 1'b1);
        // Disabled: no request over several tick periods
        toy_host_model_inst.ctl(1'b0);
        hits = 0;
        repeat (3 * DIV) begin
            @(negedge clk);
            hits += (irq_req !== 1'b0);
        end
        check(hits, 0);
        final_report();
    end
endmodule
`default_nettype wire

/* sim/toy_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Host core: register cycles, acknowledge, battery flag upkeep
// ----------------------------------------------------------------
module toy_host_model
    import toy_timer_pkg::*;
(
    input wire logic CLK,
    output logic IPR_WR,
    output logic IPR_RD,
    output logic [7:0] IPR_NUM,
    output logic [31:0] IPR_WDATA,
    input wire logic [31:0] IPR_RDATA,
    input wire logic IPR_RD_VALID,
    output logic IACK,
    output logic [4:0] IACK_LEVEL,
    input wire logic IRQ_CLAIM,
    output logic BATTERY_LOW
);
    // Idle values; data is scrambled between cycles so stale data never passes
    initial begin
        IPR_WR = 1'b0;
        IPR_RD = 1'b0;
        IPR_NUM = 8'h00;
        IPR_WDATA = 32'h0;
        IACK = 1'b0;
        IACK_LEVEL = 5'h00;
        BATTERY_LOW = 1'b0;
    end
    // One-cycle write strobe launched on the falling edge
    task automatic wr(input logic [7:0] num, input logic [31:0] data);
        @(negedge CLK);
        IPR_NUM = num;
        IPR_WDATA = data;
        IPR_WR = 1'b1;
        @(negedge CLK);
        IPR_WR = 1'b0;
        IPR_WDATA = ~data;
    endtask
    // Read: data is taken the cycle after the strobe
    task automatic rd(input logic [7:0] num, output logic [31:0] d, output logic ok);
        @(negedge CLK);
        IPR_NUM = num;
        IPR_RD = 1'b1;
        @(negedge CLK);
        IPR_RD = 1'b0;
        IPR_NUM = ~num;
        ok = IPR_RD_VALID;
        d = IPR_RDATA;
    endtask
    // Control writes keep every reserved bit at zero
    task automatic ctl(input logic en);
        wr(INTERVAL_CLOCK_CONTROL_IDX, {25'h0, en, 6'h00});
    endtask
    // Load the counter first, then clear the flag, so no clear is lost
    task automatic reload(input logic [31:0] v);
        wr(TIME_OF_YEAR_COUNT_IDX, v);
        BATTERY_LOW = 1'b0;
    endtask
    // Config logic reports a weak battery
    task automatic low_battery();
        @(negedge CLK);
        BATTERY_LOW = 1'b1;
    endtask
    // Acknowledge at a level; claim is combinational, looked at mid-cycle
    task automatic ack(input logic [4:0] level, output logic claim);
        @(negedge CLK);
        IACK = 1'b1;
        IACK_LEVEL = level;
        #1 claim = IRQ_CLAIM;
        @(negedge CLK);
        IACK = 1'b0;
    endtask
endmodule
`default_nettype wire
